// *** ncp_buf_port.sv ***
// Internal 2K x 8 buffer with pointer, prefetch register and write staging.
// Assumes the host spaces accesses by at least one arbitration cycle.
`timescale 1ns/100ps
`include "ncp_map.svh"
module ncp_buf_port (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        load_i,
  input  wire logic [10:0] load_addr_i,
  input  wire logic        read_dir_i,
  input  wire logic        auto_i,
  input  wire logic        slow_i,
  input  wire logic        data_rd_i,
  input  wire logic        data_wr_i,
  input  wire logic [7:0]  wdata_i,
  output logic [10:0]      ptr_o,
  output logic [7:0]       data_o,
  output logic             busy_o
);
  logic [7:0]                mem [0:2047];
  ncp_pkg::ncp_buf_state_type state_r;
  logic [10:0]               op_addr_r;
  logic                      op_write_r;
  logic [7:0]                stage_r;
  logic                      start;
  logic [10:0]               next_ptr;

  assign next_ptr = ptr_o + `NCP_ADDR_STEP;
  assign start    = load_i ? read_dir_i : ((data_rd_i && auto_i) || data_wr_i);
  assign busy_o   = (state_r != ncp_pkg::NCP_BUF_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ptr_o <= `NCP_RST_ADDR;
    end else if (load_i) begin
      ptr_o <= load_addr_i;
    end else if ((data_rd_i || data_wr_i) && auto_i) begin
      ptr_o <= next_ptr;
    end
  end

  // Operation latched at request time, executed after arbitration
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      op_addr_r  <= `NCP_RST_ADDR;
      op_write_r <= 1'b0;
      stage_r    <= `NCP_RST_BYTE;
    end else if (load_i) begin
      op_addr_r  <= load_addr_i;
      op_write_r <= 1'b0;
    end else if (data_wr_i) begin
      op_addr_r  <= ptr_o;
      op_write_r <= 1'b1;
      stage_r    <= wdata_i;
    end else if (data_rd_i && auto_i) begin
      op_addr_r  <= next_ptr;
      op_write_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= ncp_pkg::NCP_BUF_IDLE;
    end else if (start) begin
      state_r <= slow_i ? ncp_pkg::NCP_BUF_ARB : ncp_pkg::NCP_BUF_XFER;
    end else begin
      unique case (state_r)
        ncp_pkg::NCP_BUF_IDLE: state_r <= ncp_pkg::NCP_BUF_IDLE;
        ncp_pkg::NCP_BUF_ARB:  state_r <= ncp_pkg::NCP_BUF_XFER;
        ncp_pkg::NCP_BUF_XFER: state_r <= ncp_pkg::NCP_BUF_IDLE;
        default:               state_r <= ncp_pkg::NCP_BUF_IDLE;
      endcase
    end
  end

  // Memory has no reset; the prefetch register, like the other registers, is defined at reset
  always_ff @(posedge clk_sys_i) begin
    if (state_r == ncp_pkg::NCP_BUF_XFER && op_write_r) begin
      mem[op_addr_r] <= stage_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      data_o <= `NCP_RST_BYTE;
    end else if (state_r == ncp_pkg::NCP_BUF_XFER && !op_write_r) begin
      data_o <= mem[op_addr_r];
    end
  end

  a_slow_arb_len: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start && slow_i |=> state_r == ncp_pkg::NCP_BUF_ARB)
    else $error("slow arbitration did not add a cycle");
  a_prefetch_done: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    load_i && read_dir_i && !slow_i ##1 !(load_i || data_rd_i || data_wr_i) [*2] |-> !busy_o)
    else $error("prefetch after pointer load not finished");
  a_slow_prefetch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    load_i && read_dir_i && slow_i ##1 !(load_i || data_rd_i || data_wr_i) [*3] |-> !busy_o)
    else $error("slow prefetch not finished");
  c_slow_fetch: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    load_i && read_dir_i && slow_i ##3 !busy_o);
endmodule // ncp_buf_port

// *** ncp_host_model.sv ***
// Host microcontroller model for the pointer/config bank.
// Assumes ncp_regs samples one-cycle strobes on the rising clock edge.
`timescale 1ns/100ps
module ncp_host_model (
  input  wire logic                 clk_sys_i,
  input  wire logic [7:0]           rdata_i,
  output ncp_pkg::ncp_host_req_type req_o
);
  initial req_o = '0;
  // Idle cycle after each strobe keeps accesses spaced for the buffer port
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys_i);
    req_o <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk_sys_i);
    req_o <= '0;
    d = rdata_i;
  endtask
  task automatic ptr(input logic [7:0] hi, input logic [7:0] lo);
    wr(3'h2, hi);
    wr(3'h3, lo);
  endtask
endmodule // ncp_host_model

// *** ncp_map.svh ***
// Offsets, sub-register codes, reset values and counts of the pointer/config bank.
// Assumes an eight-byte host register window decoded on three address bits.
`ifndef NCP_MAP_SVH
`define NCP_MAP_SVH

`define NCP_OFS_PTR_HI    3'h2
`define NCP_OFS_PTR_LO    3'h3
`define NCP_OFS_DATA      3'h4
`define NCP_OFS_CONFIG    3'h6
`define NCP_OFS_SUBREG    3'h7

`define NCP_SUB_TENT_ID   2'h0
`define NCP_SUB_NODE_ID   2'h1
`define NCP_SUB_SETUP     2'h2
`define NCP_SUB_NEXT_ID   2'h3

`define NCP_RST_BYTE      8'h00
`define NCP_RST_ADDR      11'h000
`define NCP_RST_DIV       9'h008
`define NCP_ADDR_STEP     11'h001
`define NCP_PTR_HI_RSVD   3'h0

`define NCP_NACK_LOW      8'h04
`define NCP_NACK_HIGH     8'h80
`define NCP_NACK_STEP     8'h01
`define NCP_NACK_ZERO     8'h00

`define NCP_DIV_BASE      9'h008
`define NCP_DIV_MAX       9'h100
`define NCP_CKP_LAST      3'h5

`define NCP_LINE_IDLE     1'b1

`endif

// *** ncp_pkg.sv ***
// Types shared by the pointer/config bank and its helpers.
// Assumes field order of each register from bit 7 down to bit 0.
package ncp_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ncp_host_req_type;

  typedef struct packed {
    logic       access_is_read;
    logic       pointer_auto_advance;
    logic [2:0] unused_bits;
    logic [2:0] buffer_addr_upper;
  } ncp_ptr_hi_type;

  typedef struct packed {
    logic       soft_reset;
    logic       chained_commands_on;
    logic       line_drive_permit;
    logic       long_timeout_sel_a;
    logic       long_timeout_sel_b;
    logic       open_drain_signalling;
    logic [1:0] indirect_reg_select;
  } ncp_config_type;

  typedef struct packed {
    logic       first_pulse_driver_type;
    logic       low_refusal_threshold;
    logic       short_network_scaling;
    logic       promiscuous_receive;
    logic [2:0] line_rate_divisor_sel;
    logic       halved_arbitration_clock;
  } ncp_setup_type;

  typedef enum logic [1:0] {
    NCP_BUF_IDLE,
    NCP_BUF_ARB,
    NCP_BUF_XFER
  } ncp_buf_state_type;

endpackage

// *** ncp_refusal_mon.sv ***
// Excessive free-buffer-enquiry refusal monitor.
// Assumes one-cycle pulses from the protocol engine for each refusal and acceptance.
`timescale 1ns/100ps
`include "ncp_map.svh"
module ncp_refusal_mon (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic low_thresh_i,
  input  wire logic nack_i,
  input  wire logic ack_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  logic [7:0] cnt_r;
  logic [7:0] limit;
  logic       hit;

  assign limit = low_thresh_i ? `NCP_NACK_LOW : `NCP_NACK_HIGH;
  assign hit   = nack_i && ((cnt_r + `NCP_NACK_STEP) >= limit);

  // Saturates so a long refusal run cannot wrap below the limit
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || clear_i || ack_i) begin
      cnt_r <= `NCP_NACK_ZERO;
    end else if (nack_i && cnt_r != `NCP_NACK_HIGH) begin
      cnt_r <= cnt_r + `NCP_NACK_STEP;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else if (hit) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

  a_refusal_limit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(flag_o) |-> $past(nack_i) && (($past(cnt_r) + `NCP_NACK_STEP) >= $past(limit)))
    else $error("refusal flag set before threshold");
  c_refusal_hit: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    low_thresh_i && $rose(flag_o));
endmodule // ncp_refusal_mon

// *** ncp_regs.sv ***
// Pointer, configuration and setup register bank of the network controller.
// Assumes a synchronous host port: one-cycle rd/wr pulses with address and data.
// Contract
// - Pointer high bit 7 arms a read when one, a write when zero.
// - Pointer high bit 6 set advances the pointer after each data access.
// - Pointer high bits 2-0 give buffer address bits 10 to 8.
// - Pointer high bits 5-3 have no effect on behaviour.
// - Pointer low holds address bits 7-0; writing it loads the pointer.
// - Config bit 7 soft-resets status, mask and diagnostic registers only.
// - Config bit 6 enables command chaining; low keeps single-command mode.
// - Config bit 5 low holds pulse and enable outputs inactive; resets low.
// - Config bits 4,3 select extended timeout values, same on every node.
// - Config bit 2 selects backplane signalling.
// - Config bits 1,0 route address 07 to tentative, node, setup, next.
// - Setup bit 7 picks push-pull or open drain pulse driver; open drain default.
// - Refusal flag sets after four or 128 enquiry NACKs per setup bit 6.
// - Setup bit 5 scales response and idle timeouts by three; default zero.
// - Setup bit 4 accepts all valid packets regardless of destination.
// - Acknowledge only packets addressed to the own node identifier.
// - Setup bits 3-1 double the line rate divisor per code; default 000. Codes 6 and 7 here clamp to 256, the code 5 divisor.
// - Setup bit 0 halves the arbitration clock; default low.
// - Pointer load prefetches the addressed byte; auto-advance prefetches the next.
`timescale 1ns/100ps
`include "ncp_map.svh"
module ncp_regs (
  input  wire logic                     clk_sys_i,
  input  wire logic                     sys_rst_i,
  input  wire ncp_pkg::ncp_host_req_type host_req_i,
  output logic [7:0]                    host_rdata_o,
  output logic                          buf_busy_o,
  output logic                          soft_reset_o,
  output logic                          chained_commands_on_o,
  output logic                          long_timeout_sel_a_o,
  output logic                          long_timeout_sel_b_o,
  output logic                          open_drain_signalling_o,
  output logic                          first_pulse_driver_type_o,
  output logic                          short_network_scaling_o,
  output logic                          halved_arbitration_clock_o,
  output logic [8:0]                    line_rate_divisor_o,
  output logic [1:0]                    sub_sel_o,
  output logic                          sub_wr_o,
  output logic [7:0]                    sub_wdata_o,
  input  wire logic [7:0]               sub_rdata_i,
  input  wire logic                     eng_pulse_a_n_i,
  input  wire logic                     eng_pulse_b_n_i,
  input  wire logic                     eng_driver_en_n_i,
  output logic                          line_pulse_out_a_n_o,
  output logic                          line_pulse_out_b_n_o,
  output logic                          driver_enable_out_n_o,
  input  wire logic                     pkt_valid_i,
  input  wire logic [7:0]               pkt_dest_id_i,
  input  wire logic [7:0]               node_id_i,
  output logic                          pkt_accept_o,
  output logic                          pkt_ack_o,
  input  wire logic                     fbe_nack_i,
  input  wire logic                     fbe_ack_i,
  input  wire logic                     clear_diag_i,
  output logic                          too_many_refusals_flag_o
);
  ncp_pkg::ncp_ptr_hi_type hi_r;
  ncp_pkg::ncp_config_type cfg_r;
  ncp_pkg::ncp_setup_type  setup_r;
  logic                    wr_hi;
  logic                    wr_lo;
  logic                    wr_cfg;
  logic                    wr_sub;
  logic                    wr_setup;
  logic                    data_rd;
  logic                    data_wr;
  logic [10:0]             ptr;
  logic [7:0]              buf_data;
  logic                    buf_busy;
  logic                    own_dest;
  logic [7:0]              rdata_nxt;
  logic [8:0]              div_nxt;
  logic                    refusal_flag;

  default clocking sys_cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  assign wr_hi    = host_req_i.wr && host_req_i.addr == `NCP_OFS_PTR_HI;
  assign wr_lo    = host_req_i.wr && host_req_i.addr == `NCP_OFS_PTR_LO;
  assign wr_cfg   = host_req_i.wr && host_req_i.addr == `NCP_OFS_CONFIG;
  assign wr_sub   = host_req_i.wr && host_req_i.addr == `NCP_OFS_SUBREG;
  assign wr_setup = wr_sub && cfg_r.indirect_reg_select == `NCP_SUB_SETUP;
  assign data_rd  = host_req_i.rd && host_req_i.addr == `NCP_OFS_DATA;
  assign data_wr  = host_req_i.wr && host_req_i.addr == `NCP_OFS_DATA;
  assign own_dest = pkt_dest_id_i == node_id_i;

  // Unused bits are stored but never used; readback shows them as zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hi_r <= ncp_pkg::ncp_ptr_hi_type'(`NCP_RST_BYTE);
    end else if (wr_hi) begin
      hi_r <= ncp_pkg::ncp_ptr_hi_type'(host_req_i.wdata);
    end
  end

  // Soft reset bit lives here, so a soft reset never clears this register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg_r <= ncp_pkg::ncp_config_type'(`NCP_RST_BYTE);
    end else if (wr_cfg) begin
      cfg_r <= ncp_pkg::ncp_config_type'(host_req_i.wdata);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      setup_r <= ncp_pkg::ncp_setup_type'(`NCP_RST_BYTE);
    end else if (wr_setup) begin
      setup_r <= ncp_pkg::ncp_setup_type'(host_req_i.wdata);
    end
  end

  ncp_buf_port u_buf (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .load_i      (wr_lo),
    .load_addr_i ({hi_r.buffer_addr_upper, host_req_i.wdata}),
    .read_dir_i  (hi_r.access_is_read),
    .auto_i      (hi_r.pointer_auto_advance),
    .slow_i      (setup_r.halved_arbitration_clock),
    .data_rd_i   (data_rd),
    .data_wr_i   (data_wr),
    .wdata_i     (host_req_i.wdata),
    .ptr_o       (ptr),
    .data_o      (buf_data),
    .busy_o      (buf_busy)
  );

  ncp_refusal_mon u_refusal (
    .clk_sys_i    (clk_sys_i),
    .sys_rst_i    (sys_rst_i),
    .low_thresh_i (setup_r.low_refusal_threshold),
    .nack_i       (fbe_nack_i),
    .ack_i        (fbe_ack_i),
    .clear_i      (cfg_r.soft_reset || clear_diag_i),
    .flag_o       (refusal_flag)
  );

  // Pointer readback shows the live pointer so software can count transfers
  always_comb begin
    rdata_nxt = `NCP_RST_BYTE;
    unique case (host_req_i.addr)
      `NCP_OFS_PTR_HI: rdata_nxt = {hi_r.access_is_read, hi_r.pointer_auto_advance,
                                    `NCP_PTR_HI_RSVD, ptr[10:8]};
      `NCP_OFS_PTR_LO: rdata_nxt = ptr[7:0];
      `NCP_OFS_DATA:   rdata_nxt = buf_data;
      `NCP_OFS_CONFIG: rdata_nxt = cfg_r;
      `NCP_OFS_SUBREG: rdata_nxt = (cfg_r.indirect_reg_select == `NCP_SUB_SETUP) ?
                                   setup_r : sub_rdata_i;
      default:         rdata_nxt = `NCP_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= `NCP_RST_BYTE;
    end else if (host_req_i.rd) begin
      host_rdata_o <= rdata_nxt;
    end
  end

  // Codes above the last usable one are reserved; clamp to the largest divisor
  always_comb begin
    div_nxt = `NCP_DIV_MAX;
    if (setup_r.line_rate_divisor_sel <= `NCP_CKP_LAST) begin
      div_nxt = 9'(`NCP_DIV_BASE << setup_r.line_rate_divisor_sel);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      line_rate_divisor_o <= `NCP_RST_DIV;
    end else begin
      line_rate_divisor_o <= div_nxt;
    end
  end

  // Engine requests are gated one cycle late; idle level is high on all lines
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      line_pulse_out_a_n_o  <= `NCP_LINE_IDLE;
      line_pulse_out_b_n_o  <= `NCP_LINE_IDLE;
      driver_enable_out_n_o <= `NCP_LINE_IDLE;
    end else if (!cfg_r.line_drive_permit) begin
      line_pulse_out_a_n_o  <= `NCP_LINE_IDLE;
      line_pulse_out_b_n_o  <= `NCP_LINE_IDLE;
      driver_enable_out_n_o <= `NCP_LINE_IDLE;
    end else begin
      line_pulse_out_a_n_o  <= eng_pulse_a_n_i;
      line_pulse_out_b_n_o  <= eng_pulse_b_n_i;
      driver_enable_out_n_o <= eng_driver_en_n_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pkt_accept_o <= 1'b0;
      pkt_ack_o    <= 1'b0;
    end else begin
      pkt_accept_o <= pkt_valid_i && (own_dest || setup_r.promiscuous_receive);
      pkt_ack_o    <= pkt_valid_i && own_dest;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sub_wr_o    <= 1'b0;
      sub_wdata_o <= `NCP_RST_BYTE;
      sub_sel_o   <= `NCP_SUB_TENT_ID;
    end else begin
      sub_wr_o    <= wr_sub && !wr_setup;
      sub_wdata_o <= host_req_i.wdata;
      sub_sel_o   <= cfg_r.indirect_reg_select;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      buf_busy_o               <= 1'b0;
      too_many_refusals_flag_o <= 1'b0;
    end else begin
      buf_busy_o               <= buf_busy;
      too_many_refusals_flag_o <= refusal_flag;
    end
  end

  // Plain register fields are already flip-flops and leave directly
  assign soft_reset_o               = cfg_r.soft_reset;
  assign chained_commands_on_o      = cfg_r.chained_commands_on;
  assign long_timeout_sel_a_o       = cfg_r.long_timeout_sel_a;
  assign long_timeout_sel_b_o       = cfg_r.long_timeout_sel_b;
  assign open_drain_signalling_o    = cfg_r.open_drain_signalling;
  assign first_pulse_driver_type_o  = setup_r.first_pulse_driver_type;
  assign short_network_scaling_o    = setup_r.short_network_scaling;
  assign halved_arbitration_clock_o = setup_r.halved_arbitration_clock;

  a_ptr_load_addr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo |=> ptr == {$past(hi_r.buffer_addr_upper), $past(host_req_i.wdata)})
    else $error("pointer low write did not load full address");
  a_auto_advance: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    data_rd && !wr_lo && hi_r.pointer_auto_advance |=> ptr == $past(ptr) + `NCP_ADDR_STEP)
    else $error("pointer did not advance");
  a_fixed_pointer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (data_rd || data_wr) && !wr_lo && !hi_r.pointer_auto_advance |=> $stable(ptr))
    else $error("pointer moved without auto advance");
  a_drive_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !cfg_r.line_drive_permit |=> line_pulse_out_a_n_o && line_pulse_out_b_n_o
                                 && driver_enable_out_n_o)
    else $error("line driven while transmit disabled");
  a_ack_own_id: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    pkt_ack_o |-> $past(pkt_valid_i) && $past(pkt_dest_id_i) == $past(node_id_i))
    else $error("acknowledge for foreign destination");
  a_accept_all: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    pkt_valid_i && setup_r.promiscuous_receive |=> pkt_accept_o)
    else $error("receive-all packet not accepted");
  a_soft_rst_diag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cfg_r.soft_reset && !fbe_nack_i ##1 cfg_r.soft_reset && !fbe_nack_i
    |=> !too_many_refusals_flag_o)
    else $error("soft reset left refusal flag set");
  a_setup_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_sub && cfg_r.indirect_reg_select != `NCP_SUB_SETUP |=> $stable(setup_r) && sub_wr_o)
    else $error("address 07 write misrouted");
  a_rate_divisor: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    setup_r.line_rate_divisor_sel == 3'h0 ##1 setup_r.line_rate_divisor_sel == 3'h0
    |-> line_rate_divisor_o == `NCP_DIV_BASE)
    else $error("base divisor wrong");

  a_setup_load: assert property (
    wr_setup |=> setup_r == $past(host_req_i.wdata))
    else $error("setup write lost");
  a_cfg_kept: assert property (
    cfg_r.soft_reset && !wr_cfg |=> $stable(cfg_r))
    else $error("config disturbed by soft reset");
  a_hi_no_load: assert property (
    wr_hi && !data_rd |=> $stable(ptr))
    else $error("pointer high write moved pointer");
  a_line_follow: assert property (
    cfg_r.line_drive_permit |=> line_pulse_out_a_n_o == $past(eng_pulse_a_n_i)
    && driver_enable_out_n_o == $past(eng_driver_en_n_i))
    else $error("line not following engine");
  a_rate_clamp: assert property (
    setup_r.line_rate_divisor_sel > `NCP_CKP_LAST |=> line_rate_divisor_o == `NCP_DIV_MAX)
    else $error("rate code not clamped");
  a_write_no_fetch: assert property (
    wr_lo && !hi_r.access_is_read && !buf_busy |=> !buf_busy)
    else $error("write direction fetched");
  a_foreign_drop: assert property (
    pkt_valid_i && !setup_r.promiscuous_receive && !own_dest |=> !pkt_accept_o)
    else $error("foreign packet accepted");

  c_seq_read: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo && hi_r.access_is_read ##[2:4] data_rd ##[2:4] data_rd);
  c_seq_write: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo && !hi_r.access_is_read ##[2:4] data_wr ##[2:4] data_wr);
  c_promisc: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    pkt_accept_o && !pkt_ack_o);
endmodule // ncp_regs

// *** ncp_regs_tb.sv ***
// Self-checking bench for the pointer/config register bank.
// Assumes ncp_host_model drives the host port of ncp_regs.
`timescale 1ns/100ps
`include "ncp_map.svh"
module ncp_regs_tb;
  logic clk_sys_i, sys_rst_i, buf_busy_o, soft_reset_o, chained_commands_on_o, sub_wr_o;
  logic long_timeout_sel_a_o, long_timeout_sel_b_o, open_drain_signalling_o, pkt_valid_i;
  logic first_pulse_driver_type_o, short_network_scaling_o, halved_arbitration_clock_o;
  logic eng_pulse_a_n_i, eng_pulse_b_n_i, eng_driver_en_n_i, pkt_accept_o, pkt_ack_o;
  logic line_pulse_out_a_n_o, line_pulse_out_b_n_o, driver_enable_out_n_o;
  logic fbe_nack_i, fbe_ack_i, clear_diag_i, too_many_refusals_flag_o;
  logic [8:0] line_rate_divisor_o;
  logic [7:0] host_rdata_o, sub_wdata_o, sub_rdata_i, pkt_dest_id_i, node_id_i, rv, cfg;
  logic [1:0] sub_sel_o;
  logic [2:0] um [3] = '{3'h0, 3'h1, 3'h5};
  logic [7:0] cb [4] = '{8'h40, 8'h10, 8'h08, 8'h04};
  logic [7:0] bd [3] = '{8'h11, 8'h22, 8'h33};
  ncp_pkg::ncp_host_req_type host_req;
  int n_mismatch, total_checks;

  ncp_regs dut (.clk_sys_i, .sys_rst_i, .host_req_i(host_req), .host_rdata_o, .buf_busy_o,
    .soft_reset_o, .chained_commands_on_o, .long_timeout_sel_a_o, .long_timeout_sel_b_o,
    .open_drain_signalling_o, .first_pulse_driver_type_o, .short_network_scaling_o,
    .halved_arbitration_clock_o, .line_rate_divisor_o, .sub_sel_o, .sub_wr_o, .sub_wdata_o,
    .sub_rdata_i, .eng_pulse_a_n_i, .eng_pulse_b_n_i, .eng_driver_en_n_i,
    .line_pulse_out_a_n_o, .line_pulse_out_b_n_o, .driver_enable_out_n_o, .pkt_valid_i,
    .pkt_dest_id_i, .node_id_i, .pkt_accept_o, .pkt_ack_o, .fbe_nack_i, .fbe_ack_i,
    .clear_diag_i, .too_many_refusals_flag_o);
  ncp_host_model host (.clk_sys_i, .rdata_i(host_rdata_o), .req_o(host_req));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic wcfg(input logic [7:0] v);
    cfg = v;
    host.wr(`NCP_OFS_CONFIG, v);
  endtask
  task automatic wsetup(input logic [7:0] v);
    wcfg({cfg[7:2], 2'h2});
    host.wr(`NCP_OFS_SUBREG, v);
  endtask
  task automatic pkt(input logic [7:0] d, input logic [1:0] exp);
    @(negedge clk_sys_i);
    pkt_dest_id_i = d;
    pkt_valid_i = 1'b1;
    @(negedge clk_sys_i);
    pkt_valid_i = 1'b0;
    chk({pkt_accept_o, pkt_ack_o}, exp);
  endtask
  // Pulses spaced one idle cycle apart; flag lands two flops later
  task automatic nacks(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      fbe_nack_i = 1'b1;
      @(negedge clk_sys_i);
      fbe_nack_i = 1'b0;
    end
    cyc(2);
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    conclude();
  end

  initial begin
    sys_rst_i = 1'b1;
    {eng_pulse_a_n_i, eng_pulse_b_n_i, eng_driver_en_n_i} = 3'h2;
    {pkt_valid_i, fbe_nack_i, fbe_ack_i, clear_diag_i} = 4'h0;
    pkt_dest_id_i = 8'h00;
    node_id_i = 8'h2C;
    sub_rdata_i = 8'hA5;
    cfg = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    cyc(5);
    sys_rst_i = 1'b0;
    rchk(`NCP_OFS_CONFIG, 8'h00);
    rchk(`NCP_OFS_PTR_HI, 8'h00);
    chk({line_pulse_out_a_n_o, line_pulse_out_b_n_o, driver_enable_out_n_o}, 9'h007);
    chk(line_rate_divisor_o, 9'h008);
    wsetup(8'h00);
    rchk(`NCP_OFS_SUBREG, 8'h00);
    foreach (um[i]) begin
      host.wr(um[i], 8'hFF);
      rchk(um[i], 8'h00);
    end
    foreach (cb[i]) begin
      wcfg(cb[i]);
      chk({chained_commands_on_o, long_timeout_sel_a_o, long_timeout_sel_b_o,
           open_drain_signalling_o}, {cb[i][6], cb[i][4], cb[i][3], cb[i][2]});
      rchk(`NCP_OFS_CONFIG, cb[i]);
    end
    for (int s = 0; s < 4; s++) begin
      wcfg({6'h00, s[1:0]});
      host.wr(`NCP_OFS_SUBREG, 8'h3C);
      chk({sub_sel_o, sub_wr_o}, {s[1:0], s != 2});
      chk(sub_wdata_o, 8'h3C);
      rchk(`NCP_OFS_SUBREG, (s == 2) ? 8'h3C : 8'hA5);
    end
    for (int c = 0; c < 8; c++) begin
      wsetup({c[0], 1'b0, c[1], 1'b0, c[2:0], c[2]});
      cyc(1);
      chk(line_rate_divisor_o, (c < 6) ? (9'h008 << c) : 9'h100);
      chk({first_pulse_driver_type_o, short_network_scaling_o, halved_arbitration_clock_o},
          {c[0], c[1], c[2]});
    end
    chk({line_pulse_out_a_n_o, line_pulse_out_b_n_o, driver_enable_out_n_o}, 9'h007);
    wcfg(8'h22);
    cyc(1);
    chk({line_pulse_out_a_n_o, line_pulse_out_b_n_o, driver_enable_out_n_o}, 9'h002);
    {eng_pulse_a_n_i, eng_pulse_b_n_i, eng_driver_en_n_i} = 3'h5;
    cyc(2);
    chk({line_pulse_out_a_n_o, line_pulse_out_b_n_o, driver_enable_out_n_o}, 9'h005);
    wsetup(8'h00);
    pkt(8'h11, 2'h0);
    pkt(8'h2C, 2'h3);
    wsetup(8'h10);
    pkt(8'h11, 2'h2);
    pkt(8'h2C, 2'h3);
    wsetup(8'h40);
    nacks(3);
    fbe_ack_i = 1'b1;
    cyc(1);
    fbe_ack_i = 1'b0;
    nacks(3);
    chk(too_many_refusals_flag_o, 1'b0);
    nacks(1);
    chk(too_many_refusals_flag_o, 1'b1);
    clear_diag_i = 1'b1;
    cyc(1);
    clear_diag_i = 1'b0;
    fbe_ack_i = 1'b1;
    cyc(1);
    fbe_ack_i = 1'b0;
    wsetup(8'h00);
    nacks(127);
    chk(too_many_refusals_flag_o, 1'b0);
    nacks(1);
    chk(too_many_refusals_flag_o, 1'b1);
    wcfg(8'hA2);
    cyc(2);
    chk({soft_reset_o, too_many_refusals_flag_o}, 2'h2);
    rchk(`NCP_OFS_CONFIG, 8'hA2);
    wcfg(8'h22);
    chk(soft_reset_o, 1'b0);
    host.ptr(8'h7D, 8'hFE);
    rchk(`NCP_OFS_PTR_HI, 8'h45);
    rchk(`NCP_OFS_PTR_LO, 8'hFE);
    foreach (bd[i]) host.wr(`NCP_OFS_DATA, bd[i]);
    rchk(`NCP_OFS_PTR_HI, 8'h46);
    rchk(`NCP_OFS_PTR_LO, 8'h01);
    host.ptr(8'hC5, 8'hFE);
    foreach (bd[i]) begin
      cyc(1);
      rchk(`NCP_OFS_DATA, bd[i]);
    end
    wsetup(8'h01);
    host.ptr(8'h85, 8'hFF);
    cyc(1);
    chk(buf_busy_o, 1'b1);
    repeat (2) begin
      cyc(2);
      rchk(`NCP_OFS_DATA, 8'h22);
    end
    rchk(`NCP_OFS_PTR_LO, 8'hFF);
    chk(buf_busy_o, 1'b0);
    conclude();
  end
endmodule // ncp_regs_tb
